// ---- common/mie_pkg.sv ----
package mie_pkg;

    localparam int AXI_AW = 8;
    localparam int PC_W   = 12;
    localparam int DAT_W  = 8;
    localparam int MEM_AW = 8;
    localparam int MEM_DEPTH = 192;

    localparam logic [AXI_AW-1:0] REG_INSTR = 8'h00;
    localparam logic [AXI_AW-1:0] REG_ACC   = 8'h04;
    localparam logic [AXI_AW-1:0] REG_FLAGS = 8'h08;
    localparam logic [AXI_AW-1:0] REG_PC    = 8'h0c;
    localparam logic [AXI_AW-1:0] REG_MEMWR = 8'h10;
    localparam logic [AXI_AW-1:0] REG_WDT   = 8'h14;
    localparam logic [AXI_AW-1:0] REG_WAKE  = 8'h18;

    localparam int INS_OP_LSB = 0;
    localparam int INS_MA_LSB = 8;
    localparam int INS_BA_LSB = 16;
    localparam int MWR_A_LSB  = 8;
    localparam int FL_HC      = 0;
    localparam int FL_CY      = 1;
    localparam int WAKE_BIT   = 0;

    localparam logic [3:0]       BCD_LIMIT = 4'h9;
    localparam logic [3:0]       BCD_FIX   = 4'h6;
    localparam logic [DAT_W-1:0] DAT_ONE   = 8'h01;
    localparam logic [1:0]       RESP_OKAY   = 2'h0;
    localparam logic [1:0]       RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        OP_NOP = 4'h0, OP_CLR1 = 4'h1, OP_CLR2 = 4'h2, OP_INV_MEM = 4'h3,
        OP_INV_ACC = 4'h4, OP_BCD = 4'h5, OP_DEC = 4'h6, OP_MEM_MINUS_ONE_TO_ACCUMULATOR_OP = 4'h7,
        OP_INC = 4'h8, OP_MEM_PLUS_ONE_TO_ACCUMULATOR_OP = 4'h9, OP_BRANCH = 4'ha, OP_MOV = 4'hb,
        OP_SLEEP = 4'hc
    } mie_op_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001, ST_FETCH = 4'b0010, ST_EXEC = 4'b0100, ST_SLEEP = 4'b1000
    } mie_state_t;

endpackage

// ---- hw/mie_dmem.sv ----
`timescale 1ns/1ps
module mie_dmem
    import mie_pkg::*;
#(
    parameter int AW    = MEM_AW,
    parameter int DW    = DAT_W,
    parameter int DEPTH = MEM_DEPTH
)
(
    input  wire logic          aclk,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [DW-1:0] rdata
);

    // Contents have no reset so that they survive sleep and core reset alike.
    logic [DW-1:0] mem [DEPTH];

    always_ff @(posedge aclk)
    begin
        if (we && (waddr < AW'(DEPTH)))
        begin
            mem[waddr] <= wdata;
        end
        rdata <= (raddr < AW'(DEPTH)) ? mem[raddr] : '0;
    end

endmodule

// ---- hw/mie_bcd.sv ----
`timescale 1ns/1ps
module mie_bcd
    import mie_pkg::*;
(
    input  wire logic [7:0] acc,
    input  wire logic       half_carry_flag,
    input  wire logic       msb_overflow_bit,
    output logic      [7:0] result,
    output logic            msb_overflow_out
);

    logic       low_adj;
    logic       low_nibble_adjust_carry;
    logic [4:0] hsum;

    always_comb
    begin
        low_adj = (acc[3:0] > BCD_LIMIT) || half_carry_flag;
        result[3:0] = low_adj ? 4'(acc[3:0] + BCD_FIX) : acc[3:0];
        low_nibble_adjust_carry = low_adj ? !half_carry_flag : 1'b0;
        hsum = {1'b0, acc[7:4]} + {4'h0, low_nibble_adjust_carry};
        if ((hsum > {1'b0, BCD_LIMIT}) || msb_overflow_bit)
        begin
            result[7:4] = 4'(hsum + {1'b0, BCD_FIX});
            msb_overflow_out = 1'b1;
        end
        else
        begin
            result[7:4] = hsum[3:0];
            msb_overflow_out = msb_overflow_bit;
        end
    end

endmodule

// ---- hw/mie_core.sv ----
// How it works
// - Complement writes the ones-complement of the memory byte back to it.
// - Complement-to-accumulator never writes data memory.
// - Low nibble above nine or half carry adds six; adjust carry is inverted half carry when adjusting, else zero.
// - High nibble plus adjust carry above nine or overflow adds six, sets overflow.
// - Adjust result goes to memory; only the overflow flag may change.
// - Decrement writes memory byte minus one back to it.
// - Decrement-to-accumulator loads byte minus one, memory untouched.
// - Sleep halts execution, stops system clock, keeps all other state.
// - Sleep clears watchdog counter and prescaler.
// - Sleep sets sleep flag, clears expired flag, advances program counter.
// - Increment writes memory byte plus one back to it.
// - Increment-to-accumulator loads byte plus one, memory untouched.
// - Direct branch loads the program counter from the instruction address.
// - Copy loads the accumulator with the memory byte.
//
// The AXI4-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ps
module mie_core
    import mie_pkg::*;
#(
    parameter int PRE_W = 7,
    parameter int WDT_W = 8
)
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [AXI_AW-1:0] s_axi_awaddr,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    output logic      [1:0]        s_axi_bresp,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    input  wire logic [AXI_AW-1:0] s_axi_araddr,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic      [31:0]       s_axi_rdata,
    output logic      [1:0]        s_axi_rresp,
    output logic                   sys_clk_stopped
);

    typedef struct packed {
        mie_state_t        state;
        mie_op_t           op;
        logic [MEM_AW-1:0] maddr;
        logic [PC_W-1:0]   baddr;
        logic [PC_W-1:0]   pc;
        logic [DAT_W-1:0]  acc;
        logic              hc;
        logic              cy;
        logic              sleepf;
        logic              expf;
        logic              clr1;
        logic              clr2;
        logic [PRE_W-1:0]  pre;
        logic [WDT_W-1:0]  wdt;
        logic              aw_h;
        logic [AXI_AW-1:0] aw_a;
        logic              w_h;
        logic [31:0]       w_d;
        logic [3:0]        w_s;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
        logic              mem_we;
        logic [MEM_AW-1:0] mem_wa;
        logic [DAT_W-1:0]  mem_wd;
    } mie_core_t;

    localparam mie_core_t CORE_RST = '{state: ST_IDLE, op: OP_NOP, default: '0};

    mie_core_t        st;
    mie_core_t        next_st;
    logic [DAT_W-1:0] mem_rdata;
    logic [DAT_W-1:0] bcd_res;
    logic             bcd_cy;
    logic             expire_evt;
    logic             ex;
    logic [32:0]      wr_old;
    logic [32:0]      rd_val;
    logic [31:0]      wd;

    mie_dmem u_dmem (
        .aclk  (aclk),
        .we    (st.mem_we),
        .waddr (st.mem_wa),
        .wdata (st.mem_wd),
        .raddr (st.maddr),
        .rdata (mem_rdata)
    );

    mie_bcd u_bcd (
        .acc              (st.acc),
        .half_carry_flag  (st.hc),
        .msb_overflow_bit (st.cy),
        .result           (bcd_res),
        .msb_overflow_out (bcd_cy)
    );

    // Returns a hit bit above the 32-bit read value of a register.
    function automatic logic [32:0] rd_reg(input mie_core_t s, input logic [AXI_AW-1:0] a);
        logic [32:0] r;
        r = '0;
        case (a)
            REG_INSTR: r = {1'b1, 4'h0, s.baddr, s.maddr, 4'h0, s.op};
            REG_ACC:   r = {1'b1, 24'h0, s.acc};
            REG_FLAGS: r = {1'b1, 27'h0, s.state != ST_IDLE, s.expf, s.sleepf, s.cy, s.hc};
            REG_PC:    r = {1'b1, {(32-PC_W){1'b0}}, s.pc};
            REG_MEMWR: r = {1'b1, 16'h0, s.mem_wa, s.mem_wd};
            REG_WDT:   r = {1'b1, {(32-WDT_W){1'b0}}, s.wdt};
            REG_WAKE:  r = {1'b1, 32'h0};
            default:   r = '0;
        endcase
        return r;
    endfunction

    // Byte lanes without a strobe keep the register's present value.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                m[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return m;
    endfunction

    assign ex         = st.state == ST_EXEC;
    assign expire_evt = (&st.pre) && (&st.wdt);
    assign wr_old     = rd_reg(st, st.aw_a);
    assign rd_val     = rd_reg(st, s_axi_araddr);
    assign wd         = merge(wr_old[31:0], st.w_d, st.w_s);

    always_comb
    begin
        next_st = st;
        next_st.mem_we = 1'b0;
        // Free-running watchdog with its prescaler.
        next_st.pre = PRE_W'(st.pre + 1'b1);
        if (&st.pre)
        begin
            next_st.wdt = WDT_W'(st.wdt + 1'b1);
        end
        if (s_axi_awvalid && !st.aw_h)
        begin
            next_st.aw_h = 1'b1;
            next_st.aw_a = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st.w_h)
        begin
            next_st.w_h = 1'b1;
            next_st.w_d = s_axi_wdata;
            next_st.w_s = s_axi_wstrb;
        end
        if (st.bvalid && s_axi_bready)
        begin
            next_st.bvalid = 1'b0;
        end
        if (st.aw_h && st.w_h && !st.bvalid)
        begin
            next_st.aw_h = 1'b0;
            next_st.w_h = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = wr_old[32] ? RESP_OKAY : RESP_SLVERR;
            case (st.aw_a)
                REG_INSTR:
                begin
                    if (st.state == ST_IDLE)
                    begin
                        next_st.op = mie_op_t'(wd[INS_OP_LSB +: 4]);
                        next_st.maddr = wd[INS_MA_LSB +: MEM_AW];
                        next_st.baddr = wd[INS_BA_LSB +: PC_W];
                        next_st.state = ST_FETCH;
                    end
                end
                REG_ACC:   next_st.acc = wd[DAT_W-1:0];
                REG_FLAGS:
                begin
                    next_st.hc = wd[FL_HC];
                    next_st.cy = wd[FL_CY];
                end
                REG_PC:    next_st.pc = wd[PC_W-1:0];
                REG_MEMWR:
                begin
                    if (st.state == ST_IDLE)
                    begin
                        next_st.mem_we = 1'b1;
                        next_st.mem_wa = wd[MWR_A_LSB +: MEM_AW];
                        next_st.mem_wd = wd[DAT_W-1:0];
                    end
                end
                REG_WAKE:
                begin
                    if ((st.state == ST_SLEEP) && wd[WAKE_BIT])
                    begin
                        next_st.state = ST_IDLE;
                    end
                end
                default: ;
            endcase
        end
        if (s_axi_arvalid && !st.rvalid)
        begin
            next_st.rvalid = 1'b1;
            next_st.rdata = rd_val[31:0];
            next_st.rresp = rd_val[32] ? RESP_OKAY : RESP_SLVERR;
        end
        else if (st.rvalid && s_axi_rready)
        begin
            next_st.rvalid = 1'b0;
        end
        case (st.state)
            ST_IDLE: ;
            ST_FETCH: next_st.state = ST_EXEC;
            ST_EXEC:
            begin
                next_st.state = ST_IDLE;
                next_st.pc = PC_W'(st.pc + 1'b1);
                case (st.op)
                    OP_CLR1, OP_CLR2:
                    begin
                        if ((st.op == OP_CLR1 && st.clr2) || (st.op == OP_CLR2 && st.clr1))
                        begin
                            next_st.wdt = '0;
                            next_st.pre = '0;
                            next_st.sleepf = 1'b0;
                            next_st.expf = 1'b0;
                            next_st.clr1 = 1'b0;
                            next_st.clr2 = 1'b0;
                        end
                        else if (st.op == OP_CLR1)
                        begin
                            next_st.clr1 = 1'b1;
                        end
                        else
                        begin
                            next_st.clr2 = 1'b1;
                        end
                    end
                    OP_INV_MEM:
                    begin
                        next_st.mem_we = 1'b1;
                        next_st.mem_wa = st.maddr;
                        next_st.mem_wd = ~mem_rdata;
                    end
                    OP_INV_ACC: next_st.acc = ~mem_rdata;
                    OP_BCD:
                    begin
                        next_st.mem_we = 1'b1;
                        next_st.mem_wa = st.maddr;
                        next_st.mem_wd = bcd_res;
                        next_st.cy = bcd_cy;
                    end
                    OP_DEC, OP_INC:
                    begin
                        next_st.mem_we = 1'b1;
                        next_st.mem_wa = st.maddr;
                        next_st.mem_wd = (st.op == OP_DEC) ? DAT_W'(mem_rdata - DAT_ONE)
                                                           : DAT_W'(mem_rdata + DAT_ONE);
                    end
                    OP_MEM_MINUS_ONE_TO_ACCUMULATOR_OP: next_st.acc = DAT_W'(mem_rdata - DAT_ONE);
                    OP_MEM_PLUS_ONE_TO_ACCUMULATOR_OP: next_st.acc = DAT_W'(mem_rdata + DAT_ONE);
                    OP_BRANCH: next_st.pc = st.baddr;
                    OP_MOV: next_st.acc = mem_rdata;
                    OP_SLEEP:
                    begin
                        next_st.wdt = '0;
                        next_st.pre = '0;
                        next_st.sleepf = 1'b1;
                        next_st.expf = 1'b0;
                        next_st.state = ST_SLEEP;
                    end
                    default: ;
                endcase
            end
            ST_SLEEP: ;
            default: next_st.state = ST_IDLE;
        endcase
        // Expiry is set after any clear so that it is never lost, and wakes a sleeping core.
        if (expire_evt)
        begin
            next_st.expf = 1'b1;
            if (st.state == ST_SLEEP)
            begin
                next_st.state = ST_IDLE;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st <= CORE_RST;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign s_axi_awready   = !st.aw_h;
    assign s_axi_wready    = !st.w_h;
    assign s_axi_bvalid    = st.bvalid;
    assign s_axi_bresp     = st.bresp;
    assign s_axi_arready   = !st.rvalid;
    assign s_axi_rvalid    = st.rvalid;
    assign s_axi_rdata     = st.rdata;
    assign s_axi_rresp     = st.rresp;
    assign sys_clk_stopped = st.state == ST_SLEEP;

    a_inv_acc_value: assert property (@(posedge aclk) disable iff (!aresetn)
        ex && st.op == OP_INV_ACC |=> st.acc == ~$past(mem_rdata))
        else $error("Accumulator does not hold the complemented byte.");

    a_inv_acc_nowrite: assert property (@(posedge aclk) disable iff (!aresetn)
        ex && st.op == OP_INV_ACC |=> !st.mem_we ##1 !st.mem_we)
        else $error("Complement to accumulator wrote data memory.");

    a_bcd_low_fix: assert property (@(posedge aclk) disable iff (!aresetn)
        ex && st.op == OP_BCD && ((st.acc[3:0] > BCD_LIMIT) || st.hc)
        |=> st.mem_wd[3:0] == 4'($past(st.acc[3:0]) + BCD_FIX))
        else $error("Low nibble was not adjusted by six.");

    a_bcd_low_copy: assert property (@(posedge aclk) disable iff (!aresetn)
        ex && st.op == OP_BCD && (st.acc[3:0] <= BCD_LIMIT) && !st.hc
        |=> st.mem_wd[3:0] == $past(st.acc[3:0]))
        else $error("Low nibble was altered without cause.");

    a_bcd_ovf_set: assert property (@(posedge aclk) disable iff (!aresetn)
        ex && st.op == OP_BCD && (st.acc[7:4] > BCD_LIMIT) |=> st.cy)
        else $error("Overflow flag not set by a high nibble above nine.");

    a_bcd_dest_mem: assert property (@(posedge aclk) disable iff (!aresetn)
        ex && st.op == OP_BCD
        |=> st.mem_we && st.mem_wa == $past(st.maddr) && $stable(st.acc) && $stable(st.hc))
        else $error("Adjust result not sent to memory or other state changed.");

    a_dec_writeback: assert property (@(posedge aclk) disable iff (!aresetn)
        ex && st.op == OP_DEC
        |=> st.mem_we && st.mem_wa == $past(st.maddr) && st.mem_wd == DAT_W'($past(mem_rdata) - DAT_ONE))
        else $error("Decrement did not write back the byte minus one.");

    a_mem_minus_one_to_accumulator_op_acc: assert property (@(posedge aclk) disable iff (!aresetn)
        ex && st.op == OP_MEM_MINUS_ONE_TO_ACCUMULATOR_OP |=> !st.mem_we && st.acc == DAT_W'($past(mem_rdata) - DAT_ONE))
        else $error("Decrement to accumulator gave a wrong result.");

    a_sleep_stops: assert property (@(posedge aclk) disable iff (!aresetn)
        ex && st.op == OP_SLEEP && !expire_evt |=> sys_clk_stopped && $stable(st.acc))
        else $error("Sleep did not stop the clock or lost state.");

    a_sleep_wdt_clr: assert property (@(posedge aclk) disable iff (!aresetn)
        ex && st.op == OP_SLEEP |=> st.wdt == '0 && st.pre == '0)
        else $error("Sleep did not clear the watchdog.");

    a_sleep_flags: assert property (@(posedge aclk) disable iff (!aresetn)
        ex && st.op == OP_SLEEP && !expire_evt
        |=> st.sleepf && !st.expf && st.pc == PC_W'($past(st.pc) + 1'b1))
        else $error("Sleep flags or program counter wrong.");

    a_inc_writeback: assert property (@(posedge aclk) disable iff (!aresetn)
        ex && st.op == OP_INC
        |=> st.mem_we && st.mem_wa == $past(st.maddr) && st.mem_wd == DAT_W'($past(mem_rdata) + DAT_ONE))
        else $error("Increment did not write back the byte plus one.");

    a_mem_plus_one_to_accumulator_op_acc: assert property (@(posedge aclk) disable iff (!aresetn)
        ex && st.op == OP_MEM_PLUS_ONE_TO_ACCUMULATOR_OP |=> !st.mem_we && st.acc == DAT_W'($past(mem_rdata) + DAT_ONE))
        else $error("Increment to accumulator gave a wrong result.");

    a_branch_pc: assert property (@(posedge aclk) disable iff (!aresetn)
        ex && st.op == OP_BRANCH |=> st.pc == $past(st.baddr))
        else $error("Branch did not load the program counter.");

    a_mov_acc: assert property (@(posedge aclk) disable iff (!aresetn)
        ex && st.op == OP_MOV |=> !st.mem_we && st.acc == $past(mem_rdata))
        else $error("Copy did not load the accumulator.");

    a_wdt_preclear: assert property (@(posedge aclk) disable iff (!aresetn)
        ex && st.op == OP_CLR2 && !st.clr1 && !expire_evt |=> st.clr2 && $stable(st.sleepf) && $stable(st.expf))
        else $error("Lone second watchdog clear changed the flags.");

    a_wdt_paired: assert property (@(posedge aclk) disable iff (!aresetn)
        ex && ((st.op == OP_CLR2 && st.clr1) || (st.op == OP_CLR1 && st.clr2))
        |=> st.wdt == '0 && !st.sleepf && !st.clr1 && !st.clr2)
        else $error("Paired watchdog clear did not clear.");

    a_inv_mem_wb: assert property (@(posedge aclk) disable iff (!aresetn)
        ex && st.op == OP_INV_MEM |=> st.mem_we && st.mem_wd == ~$past(mem_rdata))
        else $error("Complement in memory did not write the inverted byte.");

endmodule

// ---- sim/mie_core_test.sv ----
`timescale 1ns/1ps
module mie_core_test
    import mie_pkg::*;
;
    logic              aclk    = 1'b0;
    logic              aresetn = 1'b0;
    logic              awvalid = 1'b0;
    logic              wvalid  = 1'b0;
    logic              bready  = 1'b0;
    logic              arvalid = 1'b0;
    logic              rready  = 1'b0;
    logic [AXI_AW-1:0] awaddr  = 8'h00;
    logic [AXI_AW-1:0] araddr  = 8'h00;
    logic [31:0]       wdata   = 32'h0;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic              arready;
    logic              rvalid;
    logic              stopped;
    logic [1:0]        bresp;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
    logic [31:0]       rv;
    logic [1:0]        rs;
    int                err_total  = 0;
    int                num_checks = 0;

    always #20 aclk = ~aclk;

    mie_core dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .sys_clk_stopped(stopped)
    );

    task summarize;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (1)
        begin
            @(posedge aclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid === 1'b1)
            begin
                rs = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask

    task rd(input logic [7:0] a);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        while (1)
        begin
            @(posedge aclk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid === 1'b1)
            begin
                rv = rdata;
                rs = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask

    task run(input mie_op_t op, input logic [7:0] m, input logic [11:0] b);
        wr(REG_INSTR, {4'h0, b, m, 4'h0, op});
        rv = 32'h10;
        while (rv[4] !== 1'b0)
            rd(REG_FLAGS);
    endtask

    task mset(input logic [7:0] m, input logic [7:0] d);
        wr(REG_MEMWR, {16'h0, m, d});
    endtask

    task peek(input logic [7:0] m);
        run(OP_MOV, m, 12'h0);
        rd(REG_ACC);
    endtask

    task t_inv;
        mset(8'h05, 8'ha5);
        run(OP_INV_ACC, 8'h05, 12'h0);
        rd(REG_ACC);
        chk(rv, 32'h5a);
        peek(8'h05);
        chk(rv, 32'ha5);
        run(OP_INV_MEM, 8'h05, 12'h0);
        peek(8'h05);
        chk(rv, 32'h5a);
        $display("t_inv done");
    endtask

    task t_step;
        mset(8'hbf, 8'h00);
        run(OP_MEM_MINUS_ONE_TO_ACCUMULATOR_OP, 8'hbf, 12'h0);
        rd(REG_ACC);
        chk(rv, 32'hff);
        peek(8'hbf);
        chk(rv, 32'h00);
        run(OP_DEC, 8'hbf, 12'h0);
        peek(8'hbf);
        chk(rv, 32'hff);
        run(OP_MEM_PLUS_ONE_TO_ACCUMULATOR_OP, 8'hbf, 12'h0);
        rd(REG_ACC);
        chk(rv, 32'h00);
        peek(8'hbf);
        chk(rv, 32'hff);
        run(OP_INC, 8'hbf, 12'h0);
        peek(8'hbf);
        chk(rv, 32'h00);
        $display("t_step done");
    endtask

    localparam logic [9:0] TBL [5] = '{10'h0ec, 10'h265, 10'h3c8, 10'h049, 10'h114};

    task t_bcd;
        logic [4:0] lo;
        logic [4:0] hi;
        logic       ac1;
        logic       cy;
        for (int i = 0; i < 5; i++)
        begin
            lo  = {1'b0, TBL[i][5:2]};
            ac1 = 1'b0;
            if (lo > 5'h09 || TBL[i][0])
            begin
                lo  = lo + 5'h06;
                ac1 = !TBL[i][0];
            end
            hi = {1'b0, TBL[i][9:6]} + {4'h0, ac1};
            cy = TBL[i][1];
            if (hi > 5'h09 || TBL[i][1])
            begin
                hi = hi + 5'h06;
                cy = 1'b1;
            end
            mset(8'h07, 8'h00);
            wr(REG_ACC, {24'h0, TBL[i][9:2]});
            wr(REG_FLAGS, {30'h0, TBL[i][1:0]});
            run(OP_BCD, 8'h07, 12'h0);
            rd(REG_FLAGS);
            chk(rv & 32'h3, {30'h0, cy, TBL[i][0]});
            rd(REG_ACC);
            chk(rv, {24'h0, TBL[i][9:2]});
            peek(8'h07);
            chk(rv, {24'h0, hi[3:0], lo[3:0]});
        end
        $display("t_bcd done");
    endtask

    task t_branch;
        run(OP_BRANCH, 8'h00, 12'habc);
        rd(REG_PC);
        chk(rv, 32'habc);
        run(OP_NOP, 8'h00, 12'h0);
        rd(REG_PC);
        chk(rv, 32'habd);
        wr(8'h1c, 32'h1);
        chk({30'h0, rs}, {30'h0, RESP_SLVERR});
        rd(8'h1c);
        chk({rv[29:0], rs}, {30'h0, RESP_SLVERR});
        $display("t_branch done");
    endtask

    task t_sleep;
        rv = 32'h0;
        while (rv[3] !== 1'b1)
            rd(REG_FLAGS);
        chk(rv & 32'h8, 32'h8);
        repeat (300) @(posedge aclk);
        rd(REG_WDT);
        chk({31'h0, rv !== 32'h0}, 32'h1);
        wr(REG_PC, 32'h10);
        wr(REG_ACC, 32'h3c);
        wr(REG_INSTR, {28'h0, OP_SLEEP});
        while (stopped !== 1'b1)
            @(posedge aclk);
        rd(REG_WDT);
        chk(rv, 32'h0);
        rd(REG_FLAGS);
        chk(rv & 32'hc, 32'h4);
        rd(REG_PC);
        chk(rv, 32'h11);
        wr(REG_INSTR, {28'h0, OP_MEM_PLUS_ONE_TO_ACCUMULATOR_OP});
        rd(REG_ACC);
        chk(rv, 32'h3c);
        chk({31'h0, stopped}, 32'h1);
        wr(REG_WAKE, 32'h1);
        rd(REG_FLAGS);
        chk({31'h0, stopped}, 32'h0);
        $display("t_sleep done");
    endtask

    task t_wdt;
        repeat (300) @(posedge aclk);
        run(OP_CLR2, 8'h00, 12'h0);
        rd(REG_WDT);
        chk({31'h0, rv !== 32'h0}, 32'h1);
        rd(REG_FLAGS);
        chk(rv & 32'h4, 32'h4);
        run(OP_CLR1, 8'h00, 12'h0);
        rd(REG_WDT);
        chk(rv, 32'h0);
        rd(REG_FLAGS);
        chk(rv & 32'hc, 32'h0);
        $display("t_wdt done");
    endtask

    initial
    begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        t_inv;
        t_step;
        t_bcd;
        t_branch;
        t_sleep;
        t_wdt;
        summarize;
    end

    initial
    begin
        repeat (40000) @(posedge aclk);
        err_total++;
        $display("BAD %0t run did not complete in time", $time);
        summarize;
    end
endmodule
